// File: sts_ctrl.sv
// start-up timeout response, soft-off sequencing and summary status byte
module sts_ctrl
	import sts_pkg::*;
#(
	parameter int QTR_MS_CYCLES = QTR_MS_CYCLES_DEF
) (
	input wire logic SYS_CLK,
	input wire logic RESETN,
	input wire sts_cmd_t CMD,
	input wire sts_flt_t FAULTS,
	input wire logic ENABLE,
	input wire logic VOUT_REACHED,
	input wire logic [7:0] STARTUP_LIMIT,
	input wire logic [6:0] SOFT_START,
	input wire logic BUSY_EVENT,
	input wire logic TIMEOUT_CLEAR,
	input wire logic CML_CLEAR,
	output logic [15:0] RDATA,
	output logic RDATA_VALID,
	output logic CONVERTING,
	output logic SOFT_STOP_ACTIVE,
	output logic OUTPUT_VOLTAGE_STATUS_TIMEOUT,
	output logic ALERT_O,
	output logic ALERT_OE
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	sts_state_t state;
	sts_state_t next_state;
	logic [7:0] resp;
	logic [15:0] toff;
	logic [15:0] fall;
	logic [15:0] div;
	logic [15:0] tmr;
	logic [2:0] attempts;
	logic busy;
	logic inv;
	logic tmo_event;
	logic attempt_inc;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire [1:0] act = resp[RESP_HI:RESP_LO];
	wire [2:0] retry = resp[RETRY_HI:RETRY_LO];
	wire [2:0] dly = resp[DLY_HI:DLY_LO];
	wire tick = (div == 16'(QTR_MS_CYCLES - 1));
	wire wr = CMD.valid & CMD.write;
	wire rd = CMD.valid & ~CMD.write;
	wire wr_resp = wr & (CMD.code == CMD_RESP);
	wire wr_toff = wr & (CMD.code == CMD_TOFF);
	wire wr_fall = wr & (CMD.code == CMD_FALL);
	wire [4:0] w_exp = CMD.data[EXP_HI:EXP_LO];
	wire [10:0] w_man = CMD.data[MAN_HI:0];
	wire resp_ok = (CMD.data[RESP_HI:RESP_LO] != ACT_BAD);
	// unsigned compare also rejects negative mantissas
	wire toff_ok = (w_exp == TOFF_EXP) & (w_man <= TOFF_MAN_MAX);
	wire fall_ok = (w_exp == FALL_EXP) & (w_man <= FALL_MAN_MAX);
	wire [10:0] fall_man_adj = (w_man < FALL_MAN_MIN) ? FALL_MAN_MIN : w_man;
	wire inv_set = (wr_resp & ~resp_ok) | (wr_toff & ~toff_ok) | (wr_fall & ~fall_ok);
	wire busy_clr_b = wr & (CMD.code == CMD_SBYTE) & (CMD.data[7:0] == BUSY_CLR_VAL);
	wire busy_clr_w = wr & (CMD.code == CMD_SWORD) & (CMD.data[7:0] == BUSY_CLR_VAL)
		& (CMD.data[15:9] == 7'h00);
	wire busy_clr = busy_clr_b | busy_clr_w;

	// ----------------------------------------
	// timing thresholds in quarter-ms ticks, latency in clock cycles
	// ----------------------------------------
	wire [15:0] limit_ticks = {7'h00, STARTUP_LIMIT, 1'b0};
	wire tmo_hit = (STARTUP_LIMIT != 8'h00) & (tmr >= limit_ticks);
	wire [2:0] dly_ms = (dly == 3'h0) ? 3'h1 : dly;
	wire [15:0] dly_ticks = {11'h000, dly_ms, 2'b00};
	// select 7 saturates at seven soft-starts since only seven multiples are listed
	wire [2:0] hic_mult = (dly == 3'h0) ? 3'h1 : ((dly == 3'h7) ? 3'h7 : 3'(dly + 3'h1));
	wire [9:0] hic_ticks = 10'(SOFT_START) * 10'(hic_mult);
	wire [15:0] toff_ticks = {5'h00, toff[9:0], 1'b0};
	wire [15:0] fall_ticks = {5'h00, fall[MAN_HI:0]};
	wire dly_done = (tmr >= dly_ticks);
	wire hic_done = (tmr >= {6'h00, hic_ticks});
	wire lat_done = (tmr >= 16'(LATENCY_CYCLES - 1));
	wire retry_left = (retry == RETRY_FOREVER) | (attempts < retry);
	wire can_restart = (retry != RETRY_LATCH) & retry_left;
	sts_state_t shut_target;
	assign shut_target = can_restart ? ST_HICCUP : ST_LATCH;
	wire next_conv = (next_state == ST_START) | (next_state == ST_RUN) | (next_state == ST_FDELAY)
		| (next_state == ST_LAT) | (next_state == ST_TOFF) | (next_state == ST_FALL);

	// ----------------------------------------
	// status
	// ----------------------------------------
	wire next_busy = BUSY_EVENT | (busy & ~busy_clr);
	wire next_inv = inv_set | (inv & ~CML_CLEAR);
	wire next_tmo = tmo_event | (OUTPUT_VOLTAGE_STATUS_TIMEOUT & ~TIMEOUT_CLEAR);
	// summary bits are pure mirrors of the detailed flags
	wire [7:0] sbyte = {busy, ~CONVERTING, FAULTS.ov, FAULTS.oc, FAULTS.uv, FAULTS.temp,
		FAULTS.comms_memory_logic_summary | inv, FAULTS.other | OUTPUT_VOLTAGE_STATUS_TIMEOUT};
	wire [15:0] sword = {OUTPUT_VOLTAGE_STATUS_TIMEOUT, 7'h00, sbyte};
	wire [15:0] rd_mux = (CMD.code == CMD_RESP) ? {8'h00, resp} :
		(CMD.code == CMD_TOFF) ? toff :
		(CMD.code == CMD_FALL) ? fall :
		(CMD.code == CMD_SBYTE) ? {8'h00, sbyte} :
		(CMD.code == CMD_SWORD) ? sword : 16'h0000;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		tmo_event = 1'b0;
		attempt_inc = 1'b0;
		case (state)
			ST_OFF: begin
				if (ENABLE)
					next_state = ST_START;
			end
			ST_START: begin
				if (!ENABLE)
					next_state = ST_LAT;
				else if (VOUT_REACHED)
					next_state = ST_RUN;
				else if (tmo_hit) begin
					tmo_event = 1'b1;
					if (act == ACT_IGNORE)
						next_state = ST_RUN;
					else if (act == ACT_DELAYED)
						next_state = ST_FDELAY;
					else
						next_state = shut_target;
				end
			end
			ST_RUN: begin
				if (!ENABLE)
					next_state = ST_LAT;
			end
			ST_FDELAY: begin
				if (!ENABLE)
					next_state = ST_LAT;
				else if (dly_done)
					next_state = VOUT_REACHED ? ST_RUN : shut_target;
			end
			ST_HICCUP: begin
				if (!ENABLE)
					next_state = ST_OFF;
				else if (hic_done) begin
					next_state = ST_START;
					attempt_inc = 1'b1;
				end
			end
			ST_LATCH: begin
				if (!ENABLE)
					next_state = ST_OFF;
			end
			ST_LAT: begin
				if (lat_done)
					next_state = ST_TOFF;
			end
			ST_TOFF: begin
				if (tmr >= toff_ticks)
					next_state = ST_FALL;
			end
			ST_FALL: begin
				if (tmr >= fall_ticks)
					next_state = ST_OFF;
			end
			default: next_state = ST_OFF;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state <= ST_OFF;
			div <= 16'h0000;
			tmr <= 16'h0000;
		end else begin
			state <= next_state;
			div <= tick ? 16'h0000 : 16'(div + 16'h0001);
			// latency counts raw cycles, everything else quarter-ms ticks
			if (next_state != state)
				tmr <= 16'h0000;
			else if (tick | (state == ST_LAT))
				tmr <= 16'(tmr + 16'h0001);
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			attempts <= 3'h0;
		else if ((state == ST_RUN) | (state == ST_OFF))
			attempts <= 3'h0;
		else if (attempt_inc & (attempts != 3'h7))
			attempts <= 3'(attempts + 3'h1);
	end

	// ----------------------------------------
	// command registers
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			resp <= RESP_RST;
			toff <= TOFF_RST;
			fall <= FALL_RST;
		end else begin
			if (wr_resp & resp_ok)
				resp <= CMD.data[7:0];
			if (wr_toff & toff_ok)
				toff <= CMD.data;
			if (wr_fall & fall_ok)
				fall <= {FALL_EXP, fall_man_adj};
		end
	end

	// ----------------------------------------
	// flags and outputs
	// ----------------------------------------
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			busy <= 1'b0;
			inv <= 1'b0;
			OUTPUT_VOLTAGE_STATUS_TIMEOUT <= 1'b0;
			ALERT_O <= 1'b0;
			ALERT_OE <= 1'b0;
		end else begin
			busy <= next_busy;
			inv <= next_inv;
			OUTPUT_VOLTAGE_STATUS_TIMEOUT <= next_tmo;
			ALERT_O <= 1'b0;
			// line held low until every own source is serviced
			ALERT_OE <= next_busy | next_inv | next_tmo;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 16'h0000;
			RDATA_VALID <= 1'b0;
			CONVERTING <= 1'b0;
			SOFT_STOP_ACTIVE <= 1'b0;
		end else begin
			RDATA_VALID <= rd;
			if (rd)
				RDATA <= rd_mux;
			CONVERTING <= next_conv;
			SOFT_STOP_ACTIVE <= (next_state == ST_FALL);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	AST_IGNORE_RUNS: assert property (
		(state == ST_START) && ENABLE && !VOUT_REACHED && tmo_hit && (act == ACT_IGNORE)
		|=> (state == ST_RUN) && CONVERTING
	) else $error("ignore action stopped conversion");

	AST_DELAYED_HOLDS: assert property (
		(state == ST_START) && ENABLE && !VOUT_REACHED && tmo_hit && (act == ACT_DELAYED)
		|=> (state == ST_FDELAY) && CONVERTING
	) else $error("delayed action did not keep running");

	AST_IMMED_STOP: assert property (
		(state == ST_START) && ENABLE && !VOUT_REACHED && tmo_hit && (act == 2'h2)
		|=> !CONVERTING
	) else $error("immediate action kept converting");

	AST_BAD_RESP: assert property (
		wr_resp && (CMD.data[RESP_HI:RESP_LO] == ACT_BAD)
		|=> (resp == $past(resp)) && ALERT_OE && sbyte[1]
	) else $error("invalid response write accepted");

	AST_LATCH_STAYS: assert property (
		(state == ST_LATCH) && ENABLE |=> (state == ST_LATCH) && !CONVERTING
	) else $error("latched-off state left while enabled");

	AST_RETRY_LIMIT: assert property (
		(state == ST_HICCUP) && (retry != RETRY_FOREVER) |-> (attempts < retry)
	) else $error("restart attempts exceeded count");

	AST_DELAY_TICKS: assert property (
		(state == ST_FDELAY) && ENABLE && (dly == 3'h0) && (tmr < 16'h0004) |=> (state == ST_FDELAY)
	) else $error("shutdown delay shorter than 1 ms");

	AST_TOFF_RANGE: assert property (
		(toff[MAN_HI:0] <= TOFF_MAN_MAX) && (toff[EXP_HI:EXP_LO] == TOFF_EXP)
	) else $error("turn-off wait out of range");

	AST_LATENCY: assert property (
		(state == ST_LAT) && (tmr < 16'(LATENCY_CYCLES - 1)) |=> (state == ST_LAT) && CONVERTING
	) else $error("internal latency cut short");

	AST_FALL_MIN: assert property (
		fall[MAN_HI:0] >= FALL_MAN_MIN
	) else $error("soft-stop below minimum");

	AST_BUSY_CLEAR: assert property (
		busy_clr && !BUSY_EVENT |=> !busy ##1 !busy || $past(BUSY_EVENT)
	) else $error("busy flag not cleared");

	AST_TMO_FLAGS: assert property (
		tmo_event |=> OUTPUT_VOLTAGE_STATUS_TIMEOUT && sbyte[SB_CATCH] && ALERT_OE && sword[15]
	) else $error("timeout flags not set");

	AST_OFF_LIVE: assert property (
		sbyte[SB_OFF] == ((state == ST_OFF) || (state == ST_HICCUP) || (state == ST_LATCH))
	) else $error("off bit disagrees with conversion");

	AST_RESTART_CLR: assert property (
		(state == ST_RUN) |=> (attempts == 3'h0)
	) else $error("restart counter not cleared");

	AST_RETRY_FOREVER: assert property (
		(state == ST_START) && ENABLE && !VOUT_REACHED && tmo_hit && (act == 2'h2) && (retry == RETRY_FOREVER)
		|=> (state == ST_HICCUP)
	) else $error("unlimited retry did not enter hiccup");

	AST_HICCUP_MIN: assert property (
		(state == ST_HICCUP) && ENABLE && (tmr < {9'h000, SOFT_START}) |=> (state == ST_HICCUP)
	) else $error("hiccup shorter than one soft-start");

	AST_TOFF_WAIT: assert property (
		(state == ST_TOFF) && (tmr < toff_ticks) |=> (state == ST_TOFF) && CONVERTING
	) else $error("turn-off wait cut short");

	AST_FALL_START: assert property (
		(state == ST_TOFF) && (next_state == ST_FALL) |=> SOFT_STOP_ACTIVE && CONVERTING
	) else $error("soft stop did not start after the wait");

	AST_SWORD_LOW: assert property (
		rd && (CMD.code == CMD_SWORD) |=> RDATA_VALID && (RDATA[7:0] == $past(sbyte))
	) else $error("status word low byte differs from summary");

	AST_LIMIT_OFF: assert property (
		(STARTUP_LIMIT == 8'h00) |-> !tmo_event
	) else $error("timeout declared with zero limit");

	AST_ALERT_HELD: assert property (
		busy || inv || OUTPUT_VOLTAGE_STATUS_TIMEOUT |-> ALERT_OE
	) else $error("alert released while a source is set");

	COV_HICCUP_RETRY: cover property ((state == ST_HICCUP) ##1 (state == ST_START));
	COV_LATCH: cover property ((state == ST_START) ##1 (state == ST_LATCH));
	COV_SOFT_STOP: cover property ((state == ST_FALL) ##1 (state == ST_OFF));
	COV_INVALID: cover property (inv_set ##1 ALERT_OE);

endmodule

// File: sts_host.sv
// host model that issues register commands to the converter control block
module sts_host
	import sts_pkg::*;
(
	input wire logic SYS_CLK,
	output sts_cmd_t CMD
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] exp_q[$];

	// ----------------------------------------
	// command strobes
	// ----------------------------------------
	// released bus: only valid is defined, the rest churns
	task automatic idle();
		CMD = '{1'b0, 1'($urandom), 8'($urandom), 16'($urandom)};
	endtask

	// quiet until the bench has seeded the generator
	initial begin
		CMD = '0;
	end

	// one strobe, launched on the falling edge, held across one rising edge
	task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
		@(negedge SYS_CLK);
		CMD = '{1'b1, w, c, d};
		@(negedge SYS_CLK);
		idle();
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		cmd(1'b1, c, d);
	endtask

	// expected answer is noted before the strobe goes out
	task automatic rd(input logic [7:0] c, input logic [15:0] e);
		exp_q.push_back(e);
		cmd(1'b0, c, 16'h0000);
	endtask
endmodule

// File: sts_pkg.sv
// constants, state codes and carrier types of the start-up timeout and soft-off control block
package sts_pkg;

	// ----------------------------------------
	// command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_RESP = 8'h63;
	localparam logic [7:0] CMD_TOFF = 8'h64;
	localparam logic [7:0] CMD_FALL = 8'h65;
	localparam logic [7:0] CMD_SBYTE = 8'h78;
	localparam logic [7:0] CMD_SWORD = 8'h79;
	localparam logic [7:0] BUSY_CLR_VAL = 8'h80;

	// ----------------------------------------
	// field positions and encodings
	// ----------------------------------------
	localparam int RESP_HI = 7;
	localparam int RESP_LO = 6;
	localparam int RETRY_HI = 5;
	localparam int RETRY_LO = 3;
	localparam int DLY_HI = 2;
	localparam int DLY_LO = 0;
	localparam int EXP_HI = 15;
	localparam int EXP_LO = 11;
	localparam int MAN_HI = 10;
	localparam int SB_BUSY = 7;
	localparam int SB_OFF = 6;
	localparam int SB_CATCH = 0;
	localparam logic [1:0] ACT_IGNORE = 2'h0;
	localparam logic [1:0] ACT_DELAYED = 2'h1;
	localparam logic [1:0] ACT_BAD = 2'h3;
	localparam logic [2:0] RETRY_LATCH = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam logic [4:0] TOFF_EXP = 5'h1f;
	localparam logic [4:0] FALL_EXP = 5'h1e;
	localparam logic [10:0] TOFF_MAN_MAX = 11'h0ff;
	localparam logic [10:0] FALL_MAN_MAX = 11'h07f;
	localparam logic [10:0] FALL_MAN_MIN = 11'h002;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RESP_RST = 8'h00;
	localparam logic [15:0] TOFF_RST = 16'hf800;
	localparam logic [15:0] FALL_RST = 16'hf004;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int QTR_MS_NS = 250000;
	localparam int QTR_MS_CYCLES_DEF = QTR_MS_NS / CLK_PERIOD_NS;
	localparam int TICKS_PER_MS = 4;
	localparam int LATENCY_NS = 50000;
	localparam int LATENCY_CYCLES = LATENCY_NS / CLK_PERIOD_NS;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_OFF = 4'h0,
		ST_START = 4'h1,
		ST_RUN = 4'h2,
		ST_FDELAY = 4'h3,
		ST_HICCUP = 4'h4,
		ST_LATCH = 4'h5,
		ST_LAT = 4'h6,
		ST_TOFF = 4'h7,
		ST_FALL = 4'h8
	} sts_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [15:0] data;
	} sts_cmd_t;

	typedef struct packed {
		logic ov;
		logic oc;
		logic uv;
		logic temp;
		logic comms_memory_logic_summary;
		logic other;
	} sts_flt_t;

endpackage

// File: tb_top.sv
// self-checking bench of the start-up timeout and soft-off control block
module tb_top
	import sts_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("mismatch at %0t: got %h expected %h", $time, a, b); end end

	localparam int Q = 10;
	localparam logic [23:0] BAD[4] = '{24'h6300c0, 24'h64f900, 24'h65f080, 24'h64f000};
	localparam logic [39:0] GOOD[3] = '{40'h64f8fff8ff, 40'h65f001f002, 40'h64f802f802};
	localparam logic [15:0] RESP[5] = '{16'h8001, 16'h9003, 16'h4a02, 16'hb863, 16'h0001};
	logic SYS_CLK = 1'b0;
	logic RESETN = 1'b0;
	sts_cmd_t CMD;
	sts_flt_t FAULTS = '0;
	logic ENABLE = 1'b0, VOUT_REACHED = 1'b0, BUSY_EVENT = 1'b0, TIMEOUT_CLEAR = 1'b0, CML_CLEAR = 1'b0;
	logic [7:0] STARTUP_LIMIT = 8'h01;
	logic [6:0] SOFT_START = 7'h02;
	logic [15:0] RDATA;
	logic RDATA_VALID, CONVERTING, SOFT_STOP_ACTIVE, OUTPUT_VOLTAGE_STATUS_TIMEOUT, ALERT_O, ALERT_OE;
	logic conv_q = 1'b0;
	logic c;
	int miscompares = 0, checks = 0, cyc = 0, rises = 0;

	sts_ctrl #(.QTR_MS_CYCLES(Q)) u_sts_ctrl (.SYS_CLK, .RESETN, .CMD, .FAULTS, .ENABLE, .VOUT_REACHED,
		.STARTUP_LIMIT, .SOFT_START, .BUSY_EVENT, .TIMEOUT_CLEAR, .CML_CLEAR, .RDATA, .RDATA_VALID,
		.CONVERTING, .SOFT_STOP_ACTIVE, .OUTPUT_VOLTAGE_STATUS_TIMEOUT, .ALERT_O, .ALERT_OE);
	sts_host u_host (.SYS_CLK, .CMD);

	always #20 SYS_CLK = ~SYS_CLK;

	// ----------------------------------------
	// watchers
	// ----------------------------------------
	logic [15:0] exp_rd;

	// popped once so a mismatch report cannot consume a second note
	always @(negedge SYS_CLK) begin
		if (RDATA_VALID === 1'b1) begin
			exp_rd = u_host.exp_q.pop_front();
			`CHK(RDATA, exp_rd)
		end
	end

	always @(posedge SYS_CLK) begin
		conv_q <= CONVERTING;
		if (CONVERTING === 1'b1 && conv_q === 1'b0) begin
			rises++;
		end
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(negedge SYS_CLK);
	endtask

	task automatic pulse(ref logic s);
		@(negedge SYS_CLK);
		s = 1'b1;
		@(negedge SYS_CLK);
		s = 1'b0;
	endtask

	task automatic wait_for(ref logic s, input logic v, input int lim);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(negedge SYS_CLK);
			n++;
		end
		`CHK(s, v)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(45659));
		SOFT_START = 7'($urandom_range(4, 1));
		wait_clk(2);
		RESETN = 1'b1;
		u_host.rd(CMD_RESP, {8'h00, RESP_RST});
		u_host.rd(CMD_TOFF, TOFF_RST);
		u_host.rd(CMD_FALL, FALL_RST);
		u_host.rd(CMD_SBYTE, 16'h0040);
		u_host.rd(CMD_SWORD, 16'h0040);
		u_host.rd(8'h10, 16'h0000);
		`CHK(ALERT_O, 1'b0)
		for (int i = 0; i < 6; i++) begin
			FAULTS = sts_flt_t'(6'h01 << i);
			u_host.rd(CMD_SBYTE, 16'h0040 | (16'h0001 << i));
		end
		FAULTS = '0;
		u_host.rd(CMD_SBYTE, 16'h0040);
		// refused writes keep the old value and raise the alert until cleared
		foreach (BAD[k]) begin
			u_host.wr(BAD[k][23:16], BAD[k][15:0]);
			u_host.rd(CMD_SBYTE, 16'h0042);
			`CHK(ALERT_OE, 1'b1)
			pulse(CML_CLEAR);
			wait_clk(2);
			`CHK(ALERT_OE, 1'b0)
		end
		u_host.rd(CMD_RESP, {8'h00, RESP_RST});
		u_host.rd(CMD_TOFF, TOFF_RST);
		u_host.rd(CMD_FALL, FALL_RST);
		foreach (GOOD[k]) begin
			u_host.wr(GOOD[k][39:32], GOOD[k][31:16]);
			u_host.rd(GOOD[k][39:32], GOOD[k][15:0]);
		end
		// busy flag: only the clear value on either status command drops it
		pulse(BUSY_EVENT);
		u_host.rd(CMD_SBYTE, 16'h00c0);
		`CHK(ALERT_OE, 1'b1)
		u_host.wr(CMD_SBYTE, 16'h0040);
		u_host.rd(CMD_SBYTE, 16'h00c0);
		u_host.wr(CMD_SBYTE, {8'h00, BUSY_CLR_VAL});
		u_host.rd(CMD_SBYTE, 16'h0040);
		pulse(BUSY_EVENT);
		u_host.wr(CMD_SWORD, 16'h0080);
		u_host.rd(CMD_SWORD, 16'h0040);
		// start-up timeout responses; the output never comes up
		foreach (RESP[k]) begin
			u_host.wr(CMD_RESP, {8'h00, RESP[k][15:8]});
			rises = 0;
			ENABLE = 1'b1;
			wait_clk(800);
			c = (RESP[k][15:14] == 2'b00);
			`CHK((rises > 4) ? 8'h63 : 8'(rises), RESP[k][7:0])
			`CHK(OUTPUT_VOLTAGE_STATUS_TIMEOUT, 1'b1)
			`CHK(ALERT_OE, 1'b1)
			if (RESP[k][5:3] != RETRY_FOREVER) begin
				`CHK(CONVERTING, c)
				u_host.rd(CMD_SWORD, {8'h80, 1'b0, ~c, 6'h01});
			end
			ENABLE = 1'b0;
			if (!c) begin
				wait_for(CONVERTING, 1'b0, 2000);
				pulse(TIMEOUT_CLEAR);
				wait_clk(4);
			end
		end
		// ignore case still running: turn-off latency, wait, then soft stop
		wait_clk(1200);
		`CHK(CONVERTING, 1'b1)
		`CHK(SOFT_STOP_ACTIVE, 1'b0)
		wait_for(SOFT_STOP_ACTIVE, 1'b1, 150);
		wait_clk(10);
		`CHK(SOFT_STOP_ACTIVE, 1'b1)
		wait_for(SOFT_STOP_ACTIVE, 1'b0, 30);
		wait_for(CONVERTING, 1'b0, 5);
		pulse(TIMEOUT_CLEAR);
		wait_clk(4);
		u_host.rd(CMD_SBYTE, 16'h0040);
		// zero limit never times out; a reached output ends start-up cleanly
		STARTUP_LIMIT = 8'h00;
		u_host.wr(CMD_RESP, 16'h0080);
		ENABLE = 1'b1;
		wait_clk(100);
		`CHK(CONVERTING, 1'b1)
		`CHK(OUTPUT_VOLTAGE_STATUS_TIMEOUT, 1'b0)
		STARTUP_LIMIT = 8'h01;
		VOUT_REACHED = 1'b1;
		wait_clk(100);
		`CHK(CONVERTING, 1'b1)
		`CHK(OUTPUT_VOLTAGE_STATUS_TIMEOUT, 1'b0)
		ENABLE = 1'b0;
		wait_for(CONVERTING, 1'b0, 2000);
		VOUT_REACHED = 1'b0;
		wait_clk(4);
		`CHK(u_host.exp_q.size(), 0)
		stop_test();
	end
endmodule
